//--- rtl/tcb_defs.svh
// constants for the timer byte access and tick source block
`ifndef TCB_DEFS_SVH
`define TCB_DEFS_SVH
`define TCB_SEL_STOP 3'h0
`define TCB_SEL_DIV1 3'h1
`define TCB_SEL_DIV8 3'h2
`define TCB_SEL_DIV64 3'h3
`define TCB_SEL_DIV256 3'h4
`define TCB_SEL_DIV1024 3'h5
`define TCB_SEL_EXT_FALL 3'h6
`define TCB_SEL_EXT_RISE 3'h7
`define TCB_PRE_W 10
`define TCB_PRE_MAX 10'h3ff
`define TCB_TAP8 3
`define TCB_TAP64 6
`define TCB_TAP256 8
`define TCB_TAP1024 10
`define TCB_REG_CNT 2'h0
`define TCB_REG_CMPA 2'h1
`define TCB_REG_CMPB 2'h2
`define TCB_REG_CAP 2'h3
`define TCB_WORD_RST 16'h0000
`define TCB_BYTE_RST 8'h00
`endif

//--- rtl/tcb_pkg.sv
// types shared by the timer byte access and tick source block
package tcb_pkg;
	typedef enum logic [1:0] {
		TCB_CNT = 2'h0,
		TCB_CMPA = 2'h1,
		TCB_CMPB = 2'h2,
		TCB_CAP = 2'h3
	} tcb_reg_type;
	typedef struct packed {
		logic rd;
		logic wr;
		logic hi;
		tcb_reg_type sel;
		logic [7:0] wdata;
	} tcb_bus_type;
endpackage : tcb_pkg

//--- rtl/tcb_timer_access.sv
// byte access path to the 16-bit timer registers and tick source select
// ****************************************************************
// Functional notes
// - each 16-bit register reached as two byte accesses on the 8-bit bus
// - one 8-bit high-byte holding register shared by all 16-bit registers
// - low byte write loads holding byte and written byte in one cycle
// - low byte read copies upper half into holding register same cycle
// - compare registers read both halves directly, holding byte untouched
// - 3-bit select chooses tick source; code 1 ticks every clock
// - codes 2 to 5 pick prescaler taps 8, 64, 256, 1024
// - prescaler runs continuously and is shared by all timers
// - first prescaled tick within 1 to N+1 clocks after enable
// - prescaler reset restarts period for every connected timer
// - count pin sampled by latch then flip-flop before edge detector
// - one tick per edge; code 7 rising, code 6 falling
// - pin edge to counter update takes 2.5 to 3.5 clocks
// - external ticks bypass the prescaler
// - select 0 stops the timer, counter still accessible
// - counter write beats clear and count in same cycle
// ****************************************************************
`timescale 1ns/1ps
`default_nettype none
`include "tcb_defs.svh"
module tcb_timer_access (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire tcb_pkg::tcb_bus_type bus,
	input wire logic [2:0] tick_source_select,
	input wire logic prescaler_reset,
	input wire logic ext_count_pin,
	input wire logic cnt_clear,
	input wire logic cnt_down,
	input wire logic cap_load,
	input wire logic [15:0] cap_in,
	output logic [7:0] rdata,
	output logic timer_tick,
	output logic [15:0] count_value,
	output logic [15:0] compare_value_a,
	output logic [15:0] compare_value_b,
	output logic [15:0] capture_value
);
	import tcb_pkg::*;

	// ****************************************************************
	// prescaler and tick source
	// ****************************************************************
	logic [`TCB_PRE_W-1:0] pre_r, pre_nxt;
	logic sync1_r, sync1_nxt, sync2_r, sync2_nxt;
	logic tick_r, tick_nxt;
	logic pin_latch;

	// free-running, shared; reset affects every timer on it
	always_comb begin
		pre_nxt = prescaler_reset ? '0 : pre_r + 1'b1;
	end

	// tap fires when the low bits are all ones, the clock before they roll to zero
	function automatic logic tap_hit(input logic [`TCB_PRE_W-1:0] p,
		input int w);
		logic [`TCB_PRE_W-1:0] m;
		m = `TCB_PRE_MAX >> (`TCB_PRE_W - w);
		tap_hit = ((p & m) == m);
	endfunction : tap_hit

	// latch transparent in the high half of the clock, as a half-cycle stage
	always_latch begin
		if (clk_sys) begin
			pin_latch = ext_count_pin;
		end
	end

	always_comb begin
		sync1_nxt = pin_latch;
		sync2_nxt = sync1_r;
		tick_nxt = 1'b0;
		unique case (tick_source_select)
			`TCB_SEL_STOP: tick_nxt = 1'b0;
			`TCB_SEL_DIV1: tick_nxt = 1'b1;
			`TCB_SEL_DIV8: tick_nxt = tap_hit(pre_r, `TCB_TAP8);
			`TCB_SEL_DIV64: tick_nxt = tap_hit(pre_r, `TCB_TAP64);
			`TCB_SEL_DIV256: tick_nxt = tap_hit(pre_r, `TCB_TAP256);
			`TCB_SEL_DIV1024: tick_nxt = tap_hit(pre_r, `TCB_TAP1024);
			// no prescaler on the pin path
			`TCB_SEL_EXT_FALL: tick_nxt = sync2_r & ~sync1_r;
			`TCB_SEL_EXT_RISE: tick_nxt = ~sync2_r & sync1_r;
		endcase
	end

	// latch and sync1_r form the synchroniser; sync2_r holds the last
	// sample, so a pin edge reaches the counter in 2.5 to 3.5 clocks
	// an extra stage here would push the latency past 3.5 clocks
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pre_r <= '0;
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			tick_r <= 1'b0;
		end else begin
			pre_r <= pre_nxt;
			sync1_r <= sync1_nxt;
			sync2_r <= sync2_nxt;
			tick_r <= tick_nxt;
		end
	end

	// ****************************************************************
	// 16-bit registers and shared holding byte
	// ****************************************************************
	logic [7:0] temp_r, temp_nxt, rdata_nxt;
	logic [15:0] cnt_r, cnt_nxt, cmpa_r, cmpa_nxt, cmpb_r, cmpb_nxt;
	logic [15:0] cap_r, cap_nxt;
	logic lo_wr, lo_rd, hi_wr;
	logic [15:0] sel_word, full_word;

	assign lo_wr = bus.wr & ~bus.hi;
	assign lo_rd = bus.rd & ~bus.hi;
	assign hi_wr = bus.wr & bus.hi;
	assign full_word = {temp_r, bus.wdata};

	always_comb begin
		unique case (bus.sel)
			TCB_CNT: sel_word = cnt_r;
			TCB_CMPA: sel_word = cmpa_r;
			TCB_CMPB: sel_word = cmpb_r;
			TCB_CAP: sel_word = cap_r;
		endcase
	end

	always_comb begin
		temp_nxt = temp_r;
		rdata_nxt = 8'h00;
		if (hi_wr) begin
			temp_nxt = bus.wdata;
		end
		if (lo_rd) begin
			rdata_nxt = sel_word[7:0];
			if (bus.sel != TCB_CMPA && bus.sel != TCB_CMPB) begin
				temp_nxt = sel_word[15:8];
			end
		end
		if (bus.rd & bus.hi) begin
			if (bus.sel == TCB_CMPA || bus.sel == TCB_CMPB) begin
				rdata_nxt = sel_word[15:8];
			end else begin
				rdata_nxt = temp_r;
			end
		end
	end

	always_comb begin
		cnt_nxt = cnt_r;
		cmpa_nxt = cmpa_r;
		cmpb_nxt = cmpb_r;
		cap_nxt = cap_r;
		if (cnt_clear) begin
			cnt_nxt = `TCB_WORD_RST;
		end else if (tick_r) begin
			cnt_nxt = cnt_down ? cnt_r - 16'h0001 : cnt_r + 16'h0001;
		end
		if (cap_load) begin
			cap_nxt = cap_in;
		end
		if (lo_wr) begin
			unique case (bus.sel)
				TCB_CNT: cnt_nxt = full_word;
				TCB_CMPA: cmpa_nxt = full_word;
				TCB_CMPB: cmpb_nxt = full_word;
				TCB_CAP: cap_nxt = full_word;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			temp_r <= `TCB_BYTE_RST;
			rdata <= `TCB_BYTE_RST;
			cnt_r <= `TCB_WORD_RST;
			cmpa_r <= `TCB_WORD_RST;
			cmpb_r <= `TCB_WORD_RST;
			cap_r <= `TCB_WORD_RST;
		end else begin
			temp_r <= temp_nxt;
			rdata <= rdata_nxt;
			cnt_r <= cnt_nxt;
			cmpa_r <= cmpa_nxt;
			cmpb_r <= cmpb_nxt;
			cap_r <= cap_nxt;
		end
	end

	assign timer_tick = tick_r;
	assign count_value = cnt_r;
	assign compare_value_a = cmpa_r;
	assign compare_value_b = cmpb_r;
	assign capture_value = cap_r;

	// ****************************************************************
	// checks
	// ****************************************************************
	a_low_write_load: assert property (
		@(posedge clk_sys) disable iff (!rstn)
		(lo_wr && bus.sel == TCB_CNT) |=> count_value == $past(full_word))
		else $error("low byte write did not load word");

	a_write_priority: assert property (
		@(posedge clk_sys) disable iff (!rstn)
		(lo_wr && bus.sel == TCB_CNT && (cnt_clear || tick_r))
		|=> count_value == $past(full_word))
		else $error("counter write lost to count or clear");

	a_temp_on_read: assert property (
		@(posedge clk_sys) disable iff (!rstn)
		(lo_rd && bus.sel == TCB_CNT) ##1 (bus.rd && bus.hi && !bus.wr)
		|=> rdata == $past(count_value[15:8], 2))
		else $error("high byte read not from holding copy");

	a_cmp_no_temp: assert property (
		@(posedge clk_sys) disable iff (!rstn)
		(bus.rd && (bus.sel == TCB_CMPA || bus.sel == TCB_CMPB) && !bus.wr)
		|=> $stable(temp_r))
		else $error("compare read disturbed holding byte");

	a_stop_no_tick: assert property (
		@(posedge clk_sys) disable iff (!rstn)
		(tick_source_select == `TCB_SEL_STOP)[*2] |-> !timer_tick)
		else $error("tick while stopped");

	a_div1_tick: assert property (
		@(posedge clk_sys) disable iff (!rstn)
		(tick_source_select == `TCB_SEL_DIV1) |=> timer_tick)
		else $error("no tick at full rate");

	a_div8_spacing: assert property (
		@(posedge clk_sys) disable iff (!rstn)
		(timer_tick && tick_source_select == `TCB_SEL_DIV8 && !prescaler_reset)
		##1 (tick_source_select == `TCB_SEL_DIV8 && !prescaler_reset)[*7]
		|-> !timer_tick)
		else $error("divide by 8 tick too early");

	a_tick_pulse: assert property (
		@(posedge clk_sys) disable iff (!rstn)
		(timer_tick && tick_source_select[2:1] == 2'b11) |=> !timer_tick)
		else $error("pin tick longer than one cycle");

	// pin edges seen by the synchroniser must tick on the next edge
	a_pin_rise_tick: assert property (
		@(posedge clk_sys) disable iff (!rstn)
		(tick_source_select == `TCB_SEL_EXT_RISE && sync1_r && !sync2_r)
		|=> timer_tick)
		else $error("rising pin edge gave no tick");

	a_pin_fall_tick: assert property (
		@(posedge clk_sys) disable iff (!rstn)
		(tick_source_select == `TCB_SEL_EXT_FALL && !sync1_r && sync2_r)
		|=> timer_tick)
		else $error("falling pin edge gave no tick");

	// a steady pin never ticks, whatever the prescaler does
	a_ext_no_prescale: assert property (
		@(posedge clk_sys) disable iff (!rstn)
		(tick_source_select[2:1] == 2'b11 && sync1_r == sync2_r)
		|=> !timer_tick)
		else $error("pin source ticked without an edge");

	a_pre_restart: assert property (
		@(posedge clk_sys) disable iff (!rstn)
		prescaler_reset |=> pre_r == '0)
		else $error("prescaler reset did not restart period");

	a_pre_free_run: assert property (
		@(posedge clk_sys) disable iff (!rstn)
		!prescaler_reset |=> pre_r == $past(pre_r) + 10'h001)
		else $error("prescaler stalled");

	a_hi_write_temp: assert property (
		@(posedge clk_sys) disable iff (!rstn)
		hi_wr |=> temp_r == $past(bus.wdata))
		else $error("high byte write missed holding byte");

	a_low_read_data: assert property (
		@(posedge clk_sys) disable iff (!rstn)
		(lo_rd && bus.sel == TCB_CNT && !bus.wr)
		|=> rdata == $past(count_value[7:0]))
		else $error("low byte read returned wrong data");

	a_count_step: assert property (
		@(posedge clk_sys) disable iff (!rstn)
		(timer_tick && !cnt_clear && !cnt_down
		&& !(lo_wr && bus.sel == TCB_CNT))
		|=> count_value == $past(count_value) + 16'h0001)
		else $error("tick did not advance counter");

	// without tick, clear or write the counter must hold
	a_stopped_hold: assert property (
		@(posedge clk_sys) disable iff (!rstn)
		(!timer_tick && !cnt_clear && !(lo_wr && bus.sel == TCB_CNT))
		|=> $stable(count_value))
		else $error("counter moved without a tick");
endmodule : tcb_timer_access
`default_nettype wire

//--- sim/tcb_pin_model.sv
// far-side source of the external count pin
`timescale 1ns/1ps
`default_nettype none
module tcb_pin_model (
	input wire logic clk_sys,
	input wire logic run,
	output logic pin
);
	int ph = 0;
	initial pin = 1'b0;
	// ****************
	// pin waveform
	// ****************
	// half period of three clocks, under clk/2.5; idle pin stands still
	always @(posedge clk_sys) begin
		if (run) begin
			ph = (ph + 1) % 3;
			if (ph == 0) begin
				pin <= ~pin;
			end
		end
	end
endmodule : tcb_pin_model
`default_nettype wire

//--- sim/tb_timer_clock_select_byte_access.sv
// bench for the timer byte access and tick source block
`timescale 1ns/1ps
`default_nettype none
module tb_timer_clock_select_byte_access;
	import tcb_pkg::*;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	tcb_bus_type bus = '0;
	logic [2:0] sel = 3'h0;
	logic pre_rst = 1'b0;
	logic dn = 1'b0;
	logic cap_load = 1'b0;
	logic [15:0] cap_in = 16'h0000;
	logic run = 1'b0;
	logic pin;
	logic [7:0] rdata;
	logic tick;
	logic [15:0] cnt_q, cmpa, cmpb, capv;
	int n_fail = 0;
	int check_count = 0;
	int cycles = 0;
	int seed = 32'h2df215c0;
	int regs[4] = '{0, 0, 0, 0};
	int div[4] = '{8, 64, 256, 1024};
	int hold = 0;
	int n, v;
	always #5 clk_sys = ~clk_sys;
	tcb_timer_access i_tcb_timer_access (.clk_sys(clk_sys), .rstn(rstn),
		.bus(bus), .tick_source_select(sel), .prescaler_reset(pre_rst),
		.ext_count_pin(pin), .cnt_clear(1'b0), .cnt_down(dn),
		.cap_load(cap_load), .cap_in(cap_in), .rdata(rdata),
		.timer_tick(tick), .count_value(cnt_q), .compare_value_a(cmpa),
		.compare_value_b(cmpb), .capture_value(capv));
	tcb_pin_model i_tcb_pin_model (.clk_sys(clk_sys), .run(run), .pin(pin));
	// ****************
	// tasks
	// ****************
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [15:0] got, input int exp);
		check_count++;
		if (got !== exp[15:0]) begin
			n_fail++;
			$display("mismatch at %0t got %h want %h", $time, got, exp[15:0]);
		end
	endtask : chk
	task automatic wr(input tcb_reg_type r, input logic h, input int d);
		@(negedge clk_sys);
		bus.wr = 1'b1;
		bus.hi = h;
		bus.sel = r;
		bus.wdata = d[7:0];
		@(negedge clk_sys);
		bus.wr = 1'b0;
		if (h) hold = d & 255;
		else regs[r] = hold * 256 + (d & 255);
	endtask : wr
	task automatic rd(input tcb_reg_type r, input logic h);
		@(negedge clk_sys);
		bus.rd = 1'b1;
		bus.hi = h;
		bus.sel = r;
		@(negedge clk_sys);
		bus.rd = 1'b0;
		if (!h && (r == TCB_CNT || r == TCB_CAP)) hold = (regs[r] >> 8) & 255;
		if (h && (r == TCB_CMPA || r == TCB_CMPB)) chk(rdata, regs[r] >> 8);
		else if (h) chk(rdata, hold);
		else chk(rdata, regs[r] & 255);
	endtask : rd
	// counts ticks seen over a number of cycles into n
	task automatic ticks(input int cyc);
		repeat (cyc) begin
			@(negedge clk_sys);
			if (tick === 1'b1) n++;
		end
	endtask : ticks
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			report_and_stop();
		end
	end
	// ****************
	// main sequence
	// ****************
	initial begin
		repeat (8) @(posedge clk_sys);
		@(negedge clk_sys);
		rstn = 1'b1;
		chk(cnt_q, 0);
		wr(TCB_CNT, 1'b1, 8'h01);
		wr(TCB_CNT, 1'b0, 8'hff);
		chk(cnt_q, regs[0]);
		rd(TCB_CNT, 1'b0);
		rd(TCB_CNT, 1'b1);
		v = $random(seed);
		wr(TCB_CMPA, 1'b1, v >> 8);
		wr(TCB_CMPA, 1'b0, v);
		wr(TCB_CMPB, 1'b0, v >> 16);
		chk(cmpa, regs[1]);
		chk(cmpb, regs[2]);
		rd(TCB_CNT, 1'b0);
		rd(TCB_CMPB, 1'b1);
		rd(TCB_CMPA, 1'b0);
		rd(TCB_CNT, 1'b1);
		@(negedge clk_sys);
		cap_in = $random(seed);
		cap_load = 1'b1;
		@(negedge clk_sys);
		cap_load = 1'b0;
		regs[3] = cap_in;
		rd(TCB_CAP, 1'b0);
		rd(TCB_CAP, 1'b1);
		n = 0;
		sel = 3'h1;
		ticks(40);
		sel = 3'h0;
		chk(n, 40);
		regs[0] += 40;
		repeat (3) @(negedge clk_sys);
		chk(cnt_q, regs[0]);
		sel = 3'h1;
		wr(TCB_CNT, 1'b0, 8'h10);
		chk(cnt_q, regs[0]);
		sel = 3'h0;
		regs[0] += 1;
		for (int i = 0; i < 4; i++) begin
			@(negedge clk_sys);
			pre_rst = 1'b1;
			@(negedge clk_sys);
			pre_rst = 1'b0;
			sel = 3'(i + 2);
			n = 0;
			ticks(div[i] * 5 / 2);
			sel = 3'h0;
			chk(n, 2);
			regs[0] += 2;
			repeat (3) @(negedge clk_sys);
		end
		chk(cnt_q, regs[0]);
		// pin is idle while the source changes, so no false tick
		for (int e = 0; e < 2; e++) begin
			sel = e ? 3'h6 : 3'h7;
			dn = e[0];
			repeat (2) @(negedge clk_sys);
			run = 1'b1;
			n = 0;
			ticks(60);
			run = 1'b0;
			ticks(8);
			sel = 3'h0;
			chk(n, 10);
			regs[0] += e ? -10 : 10;
			repeat (3) @(negedge clk_sys);
		end
		chk(cnt_q, regs[0]);
		rd(TCB_CNT, 1'b0);
		rd(TCB_CNT, 1'b1);
		report_and_stop();
	end
endmodule : tb_timer_clock_select_byte_access
`default_nettype wire
